// *** logic/bac_regs.svh ***
// Timing counts and field reset values for the bus arbiter and show-cycle logic
`ifndef BAC_REGS_SVH
`define BAC_REGS_SVH

`define BAC_CLK_NS        5
`define BAC_BG_NEG_NS     10
`define BAC_REGRANT_NS    10
`define BAC_BG_NEG_CLKS   ((`BAC_BG_NEG_NS + `BAC_CLK_NS - 1) / `BAC_CLK_NS)
`define BAC_REGRANT_CLKS  ((`BAC_REGRANT_NS + `BAC_CLK_NS - 1) / `BAC_CLK_NS)
`define BAC_CYC_CLKS      2

`define BAC_SHEN_RST      2'h0
`define BAC_SHEN_OFF      2'h0
`define BAC_SHEN_HOLD     2'h3

`endif

// *** logic/bac_pkg.sv ***
// Types shared by both ends of the arbitration link
package bac_pkg;

  localparam int BAC_ADDR_W = 24;
  localparam int BAC_DATA_W = 16;

  typedef enum logic [1:0] {
    BAC_ARB_OWN   = 2'h0,
    BAC_ARB_GRANT = 2'h1,
    BAC_ARB_EXT     = 2'h3,
    BAC_ARB_REGRANT = 2'h2
  } bac_arb_t;

  typedef enum logic {
    BAC_CYC_IDLE = 1'h0,
    BAC_CYC_RUN  = 1'h1
  } bac_cyc_t;

  typedef enum logic [1:0] {
    BAC_SZ_LONG  = 2'h0,
    BAC_SZ_BYTE  = 2'h1,
    BAC_SZ_WORD  = 2'h2,
    BAC_SZ_THREE = 2'h3
  } bac_size_t;

  typedef enum logic [1:0] {
    BAC_X_IDLE = 2'h0,
    BAC_X_REQ  = 2'h1,
    BAC_X_OWN  = 2'h3
  } bac_xst_t;

  typedef struct packed {
    logic [1:0]            req_s;
    logic [1:0]            ack_s;
    logic [1:0]            halt_s;
    logic                  arb_en;
    logic [1:0]            shen;
    bac_arb_t              arb;
    logic                  bg;
    logic [3:0]            cnt;
    bac_cyc_t              cyc;
    logic [3:0]            ccnt;
    logic                  opnd_busy;
    logic                  last;
    logic                  internal;
    logic [BAC_ADDR_W-1:0] addr;
    logic [BAC_DATA_W-1:0] data;
    logic                  write;
    bac_size_t             size;
    logic                  as;
    logic                  ds;
    logic                  drive;
    logic [BAC_DATA_W-1:0] rdata;
    logic                  done;
  } bac_dev_st_t;

  typedef struct packed {
    logic [1:0]            bg_s;
    logic [1:0]            ack_s;
    bac_xst_t              st;
    logic                  br;
    logic                  grant_acknowledge;
    logic [BAC_ADDR_W-1:0] addr;
    logic [BAC_DATA_W-1:0] data;
    logic                  write;
    logic                  strobe;
  } bac_ext_st_t;

endpackage : bac_pkg

// *** logic/bac_if.sv ***
// Arbitration and external bus wires between the device and an outside master
`timescale 1ns/1ps
interface bac_if;
  import bac_pkg::*;

  logic                  br;
  logic                  bg;
  logic                  ext_grant_acknowledge_o;
  logic                  ext_grant_acknowledge_oe;
  logic                  grant_acknowledge;
  logic [BAC_ADDR_W-1:0] dev_addr;
  logic                  dev_addr_oe;
  logic                  dev_as;
  logic                  dev_ds;
  bac_size_t             dev_size;
  logic                  dev_write;
  logic [BAC_DATA_W-1:0] dev_data;
  logic                  dev_data_oe;
  logic [BAC_ADDR_W-1:0] ext_addr;
  logic                  ext_addr_oe;
  logic                  ext_as;
  logic                  ext_ds;
  logic                  ext_write;
  logic [BAC_DATA_W-1:0] ext_data;
  logic                  ext_data_oe;
  logic [BAC_ADDR_W-1:0] addr;
  logic [BAC_DATA_W-1:0] data;
  logic                  as;
  logic                  ds;

  // Undriven lines settle to the pull levels: address low, data high
  assign grant_acknowledge = ext_grant_acknowledge_oe & ext_grant_acknowledge_o;
  assign addr  = dev_addr_oe ? dev_addr : (ext_addr_oe ? ext_addr : '0);
  assign data  = dev_data_oe ? dev_data : (ext_data_oe ? ext_data : '1);
  assign as    = dev_as | ext_as;
  assign ds    = dev_ds | ext_ds;

  modport dev (input br, grant_acknowledge, data, output bg, dev_addr, dev_addr_oe, dev_as, dev_ds,
               dev_size, dev_write, dev_data, dev_data_oe);
  modport ext (input bg, grant_acknowledge, data, output br, ext_grant_acknowledge_o, ext_grant_acknowledge_oe, ext_addr,
               ext_addr_oe, ext_as, ext_ds, ext_write, ext_data, ext_data_oe);
endinterface : bac_if

// *** logic/bac_dev.sv ***
// Device end: external bus arbitration, bus cycle sequencing and show cycles
// Contract
// [RULE1] One bus master at a time only
// [RULE2] Requests honoured in run, halt, double fault
// [RULE3] Device has lowest bus priority
// [RULE4] Order: request, grant, then acknowledge
// [RULE5] Request may come at any time
// [RULE6] Grant only at end of operand
// [RULE7] Acknowledge held for whole mastership
// [RULE8] Take bus only when granted and free
// [RULE9] Outside circuitry picks among several requesters
// [RULE10] Grant drops shortly after acknowledge changes
// [RULE11] Re-grant shortly if requests still pending
// [RULE12] Address strobe inactive during show cycles
// [RULE13] Show enable field resets to zero
// [RULE14] Show off: address driven, strobes idle, data floats
// [RULE15] Show on: data strobe and internal data out
// [RULE16] One show encoding stalls internal cycles when granted
// [RULE17] Size outputs show lane allocation
// [RULE18] Unwritten internal byte lane is indeterminate
// [RULE19] External byte write on both lanes
// [RULE20] Arbitration pins exist only if strap low
// [RULE21] Halted device floats outputs, restores later
// [RULE22] Float outputs while acknowledge held
// [RULE23] Withdrawn request drops grant, device resumes
`timescale 1ns/1ps
`include "bac_regs.svh"
module bac_dev #(
  parameter int BG_NEG_CLKS  = `BAC_BG_NEG_CLKS,
  parameter int REGRANT_CLKS = `BAC_REGRANT_CLKS,
  parameter int CYC_CLKS     = `BAC_CYC_CLKS
) (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  bac_if.dev                                  arb,
  input  wire logic                           mode_select_line_one,
  input  wire logic                           halt_in,
  input  wire logic                           dbl_fault,
  input  wire logic                           shen_wr,
  input  wire logic [1:0]                     shen_wdata,
  output logic      [1:0]                     show_cycle_enable,
  output logic                                cs_mode,
  input  wire logic                           int_req,
  input  wire logic [bac_pkg::BAC_ADDR_W-1:0] int_addr,
  input  wire logic                           int_write,
  input  wire bac_pkg::bac_size_t             int_size,
  input  wire logic [bac_pkg::BAC_DATA_W-1:0] int_wdata,
  input  wire logic [bac_pkg::BAC_DATA_W-1:0] int_rdata,
  input  wire logic                           int_is_internal,
  input  wire logic                           int_last,
  output logic                                int_ready,
  output logic                                int_done,
  output logic      [bac_pkg::BAC_DATA_W-1:0] ext_rdata,
  output logic                                ext_owned
);
  import bac_pkg::*;

  if (BG_NEG_CLKS < 1 || BG_NEG_CLKS > 15) begin : g_chk_neg
    $error("BG_NEG_CLKS must be 1..15");
  end
  if (REGRANT_CLKS < 1 || REGRANT_CLKS > 15) begin : g_chk_rg
    $error("REGRANT_CLKS must be 1..15");
  end
  if (CYC_CLKS < 1 || CYC_CLKS > 16) begin : g_chk_cyc
    $error("CYC_CLKS must be 1..16");
  end

  // Byte lanes for a write: low byte of wd is the byte written
  function automatic logic [BAC_DATA_W-1:0] bac_lanes(
    input logic [BAC_DATA_W-1:0] wd,
    input logic [BAC_DATA_W-1:0] rd,
    input bac_size_t             sz,
    input logic                  a0,
    input logic                  internal
  );
    logic [7:0] b;
    b = wd[7:0];
    if (sz != BAC_SZ_BYTE) begin
      return wd;
    end
    if (!internal) begin
      return {b, b}; // see [RULE19]
    end
    // Other lane carries whatever the internal bus holds
    return a0 ? {rd[15:8], b} : {b, rd[7:0]}; // see [RULE18]
  endfunction : bac_lanes

  bac_dev_st_t q;
  bac_dev_st_t d;
  logic        req;
  logic        ack;
  logic        halted;
  logic        show;
  logic        ext_ok;
  logic        int_ok;
  logic        boundary;
  logic        go;

  // Pins disabled by the strap look permanently idle
  assign req    = q.req_s[1] & q.arb_en; // see [RULE20]
  assign ack    = q.ack_s[1] & q.arb_en;
  assign halted = q.halt_s[1] | dbl_fault;
  assign show   = q.shen != `BAC_SHEN_OFF;

  // An external operand in flight keeps the bus until its last transfer
  assign boundary = !q.opnd_busy && !(q.cyc == BAC_CYC_RUN && !q.internal); // see [RULE6]
  // A pending request blocks new operands; halt blocks external cycles only
  assign ext_ok = q.arb == BAC_ARB_OWN && !ack && !halted
                  && (!req || q.opnd_busy); // see [RULE3] [RULE1]
  assign int_ok = !(q.shen == `BAC_SHEN_HOLD && q.arb != BAC_ARB_OWN); // see [RULE16]
  assign go     = int_req && q.cyc == BAC_CYC_IDLE && !dbl_fault
                  && (int_is_internal ? int_ok : ext_ok);

  always_comb begin
    d        = q;
    d.req_s  = {q.req_s[0], arb.br};
    d.ack_s  = {q.ack_s[0], arb.grant_acknowledge};
    d.halt_s = {q.halt_s[0], halt_in};
    d.done   = 1'b0;
    if (shen_wr) begin
      d.shen = shen_wdata;
    end

    // Arbitration runs regardless of halt or double fault
    unique case (q.arb) // see [RULE2]
      BAC_ARB_OWN: begin
        if (req && boundary) begin
          d.arb = BAC_ARB_GRANT;
          d.bg  = 1'b1; // see [RULE4] [RULE5]
        end
      end
      BAC_ARB_GRANT: begin
        if (ack) begin
          d.arb = BAC_ARB_EXT;
          d.cnt = 4'(BG_NEG_CLKS - 1);
        end else if (!req) begin
          d.arb = BAC_ARB_OWN;
          d.bg  = 1'b0; // see [RULE23]
        end
      end
      BAC_ARB_EXT: begin
        if (!ack) begin
          // A grant not yet dropped hands the bus straight on
          d.arb = q.bg ? BAC_ARB_GRANT : BAC_ARB_OWN;
          d.cnt = 4'h0;
        end else if (q.cnt != 4'h0) begin
          d.cnt = q.cnt - 4'h1;
        end else if (q.bg) begin
          d.bg  = 1'b0; // see [RULE10]
          d.cnt = 4'(REGRANT_CLKS - 1);
        end else if (req) begin
          // Lets outside priority logic pick the next master early
          d.arb = BAC_ARB_REGRANT;
          d.bg  = 1'b1; // see [RULE11] [RULE9]
        end
      end
      // Re-grant stands until the current master lets go or the request is withdrawn, so grant does not toggle
      BAC_ARB_REGRANT: begin
        if (!ack) begin
          d.arb = BAC_ARB_GRANT;
        end else if (!req) begin
          d.arb = BAC_ARB_EXT;
          d.bg  = 1'b0; // see [RULE23]
        end
      end
    endcase

    unique case (q.cyc)
      BAC_CYC_IDLE: begin
        if (go) begin
          d.cyc      = BAC_CYC_RUN;
          d.ccnt     = 4'(CYC_CLKS - 1);
          d.addr     = int_addr;
          d.write    = int_write;
          d.size     = int_size; // see [RULE17]
          d.internal = int_is_internal;
          d.last     = int_last;
          d.as       = !int_is_internal; // see [RULE12] [RULE14]
          d.ds       = !int_is_internal || show; // see [RULE15]
          d.drive    = int_write ? (!int_is_internal || show) : (int_is_internal && show);
          d.data     = int_write ? bac_lanes(int_wdata, int_rdata, int_size, int_addr[0],
                                             int_is_internal)
                                 : int_rdata;
          if (!int_is_internal) begin
            d.opnd_busy = 1'b1;
          end
        end
      end
      BAC_CYC_RUN: begin
        if (q.ccnt != 4'h0) begin
          d.ccnt = q.ccnt - 4'h1;
        end else begin
          d.cyc   = BAC_CYC_IDLE;
          d.as    = 1'b0;
          d.ds    = 1'b0;
          d.drive = 1'b0;
          d.done  = 1'b1;
          if (!q.internal) begin
            d.opnd_busy = !q.last;
            if (!q.write) begin
              d.rdata = arb.data;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q        <= '0;
      q.shen   <= `BAC_SHEN_RST; // see [RULE13]
      // Strap is sampled on every clocked reset edge; last one before release wins
      q.arb_en <= !mode_select_line_one; // see [RULE20]
    end else begin
      q <= d;
    end
  end

  // Address, strobes, write and data float while the synchronised acknowledge shows an outside master holds the bus; size stays driven
  assign arb.dev_addr_oe = !ack; // see [RULE22] [RULE21]
  assign arb.dev_addr    = q.addr;
  assign arb.dev_size    = q.size;
  assign arb.dev_write   = q.write & !ack;
  assign arb.dev_as      = q.as & !ack;
  assign arb.dev_ds      = q.ds & !ack;
  assign arb.dev_data    = q.data;
  assign arb.dev_data_oe = q.drive & !ack; // see [RULE14]
  assign arb.bg          = q.bg & q.arb_en;

  assign show_cycle_enable = q.shen;
  assign cs_mode           = !q.arb_en;
  assign int_ready         = go;
  assign int_done          = q.done;
  assign ext_rdata         = q.rdata;
  assign ext_owned         = ack;
endmodule : bac_dev

// *** logic/bac_ext.sv ***
// Outside master end: requests the bus, acknowledges, and runs its own cycles
`timescale 1ns/1ps
module bac_ext (
  input  wire logic                           sys_clk,
  input  wire logic                           rst_n,
  bac_if.ext                                  arb,
  input  wire logic                           want_bus,
  input  wire logic                           cyc_go,
  input  wire logic [bac_pkg::BAC_ADDR_W-1:0] cyc_addr,
  input  wire logic [bac_pkg::BAC_DATA_W-1:0] cyc_wdata,
  input  wire logic                           cyc_write,
  output logic                                owner,
  output logic                                requesting
);
  import bac_pkg::*;

  bac_ext_st_t q;
  bac_ext_st_t d;
  logic        bg;
  logic        line_busy;

  assign bg        = q.bg_s[1];
  assign line_busy = q.ack_s[1];

  always_comb begin
    d        = q;
    d.bg_s   = {q.bg_s[0], arb.bg};
    d.ack_s  = {q.ack_s[0], arb.grant_acknowledge};
    d.strobe = 1'b0;
    unique case (q.st)
      BAC_X_IDLE: begin
        if (want_bus) begin
          d.st = BAC_X_REQ;
          d.br = 1'b1; // see [RULE5] [RULE4]
        end
      end
      BAC_X_REQ: begin
        if (!want_bus) begin
          d.st = BAC_X_IDLE;
          d.br = 1'b0; // see [RULE23]
        end else if (bg && !line_busy) begin
          // Request drops as acknowledge rises
          d.st    = BAC_X_OWN;
          d.grant_acknowledge = 1'b1; // see [RULE8] [RULE1]
          d.br    = 1'b0;
        end
      end
      BAC_X_OWN: begin
        if (!want_bus) begin
          d.st    = BAC_X_IDLE;
          d.grant_acknowledge = 1'b0;
        end else if (cyc_go) begin
          d.strobe = 1'b1;
          d.addr   = cyc_addr;
          d.data   = cyc_wdata;
          d.write  = cyc_write;
        end
      end
      default: begin
        d.st    = BAC_X_IDLE;
        d.br    = 1'b0;
        d.grant_acknowledge = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign arb.br           = q.br;
  assign arb.ext_grant_acknowledge_o  = q.grant_acknowledge; // see [RULE7]
  assign arb.ext_grant_acknowledge_oe = q.grant_acknowledge;
  assign arb.ext_addr     = q.addr;
  assign arb.ext_addr_oe  = q.grant_acknowledge;
  assign arb.ext_as       = q.strobe;
  assign arb.ext_ds       = q.strobe;
  assign arb.ext_write    = q.write & q.grant_acknowledge;
  assign arb.ext_data     = q.data;
  assign arb.ext_data_oe  = q.strobe & q.write;
  assign owner            = q.grant_acknowledge;
  assign requesting       = q.br;
endmodule : bac_ext

// *** tb/bac_properties.sv ***
// Concurrent checks on the wires that join the device and the outside master
`timescale 1ns/1ps
module bac_properties
  import bac_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic br,
  input wire logic bg,
  input wire logic grant_acknowledge,
  input wire logic dev_addr_oe,
  input wire logic dev_as,
  input wire logic dev_ds,
  input wire logic dev_data_oe,
  input wire logic ext_as,
  input wire logic ext_ds
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_one_master;
    !((dev_as || dev_ds) && (ext_as || ext_ds));
  endproperty
  a_one_master: assert property (p_one_master)
    else $error("both ends strobe the bus");
  property p_grant_after_req;
    $rose(bg) |-> $past(br, 3);
  endproperty
  a_grant_after_req: assert property (p_grant_after_req)
    else $error("grant without request");
  property p_ack_after_grant;
    $rose(grant_acknowledge) |-> bg && $past(bg, 2);
  endproperty
  a_ack_after_grant: assert property (p_ack_after_grant)
    else $error("ack before grant");
  property p_grant_drop;
    $rose(grant_acknowledge) |-> ##[2:6] !bg;
  endproperty
  a_grant_drop: assert property (p_grant_drop)
    else $error("grant kept after ack");
  property p_withdraw;
    $fell(br) && !grant_acknowledge |-> ##[6:9] !bg;
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("grant kept after withdrawal");
  // Float follows a two-flop view of the acknowledge, hence the depth of two
  property p_quiet_while_ext;
    grant_acknowledge && $past(grant_acknowledge) && $past(grant_acknowledge, 2) |-> !dev_addr_oe && !dev_as && !dev_data_oe;
  endproperty
  a_quiet_while_ext: assert property (p_quiet_while_ext)
    else $error("device drives under ack");
  property p_resume_drive;
    $fell(grant_acknowledge) |-> ##[1:3] dev_addr_oe;
  endproperty
  a_resume_drive: assert property (p_resume_drive)
    else $error("address not driven again");
  property p_show_drives_data;
    dev_ds && !dev_as |-> dev_data_oe;
  endproperty
  a_show_drives_data: assert property (p_show_drives_data)
    else $error("show cycle data floats");
  property p_ext_cycle;
    $rose(dev_as) |-> dev_ds && dev_addr_oe && !grant_acknowledge;
  endproperty
  a_ext_cycle: assert property (p_ext_cycle)
    else $error("device cycle while not master");

  c_handover: cover property ($rose(grant_acknowledge));
  c_show: cover property (dev_ds && !dev_as);
  c_withdraw: cover property ($fell(br) && !grant_acknowledge);
endmodule : bac_properties

// *** tb/bus_arbitration_show_cycles_tb.sv ***
// Self-checking bench: device and outside master joined across the arbitration link
`timescale 1ns/1ps
module bus_arbitration_show_cycles_tb;
  import bac_pkg::*;
  logic                  sys_clk, rst_n, strap, halt_in, dbl_fault, shen_wr, int_req;
  logic                  int_write, int_is_internal, int_last, int_ready, int_done, cs_mode;
  logic                  want_bus, cyc_go, cyc_write, owner, ext_owned, seen_as, seen_ds;
  logic [1:0]            shen_wdata, show_cycle_enable;
  logic [BAC_ADDR_W-1:0] int_addr, cyc_addr, seen_addr;
  logic [BAC_DATA_W-1:0] int_wdata, int_rdata, ext_rdata, cyc_wdata, seen_data;
  bac_size_t             int_size, seen_size;
  int                    fails, checks_done, cycles, k;

  bac_if bac_if_i ();
  bac_dev bac_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .arb(bac_if_i),
    .mode_select_line_one(strap), .halt_in(halt_in), .dbl_fault(dbl_fault),
    .shen_wr(shen_wr), .shen_wdata(shen_wdata), .show_cycle_enable(show_cycle_enable),
    .cs_mode(cs_mode), .int_req(int_req), .int_addr(int_addr), .int_write(int_write),
    .int_size(int_size), .int_wdata(int_wdata), .int_rdata(int_rdata),
    .int_is_internal(int_is_internal), .int_last(int_last), .int_ready(int_ready),
    .int_done(int_done), .ext_rdata(ext_rdata), .ext_owned(ext_owned));
  bac_ext bac_ext_i (.sys_clk(sys_clk), .rst_n(rst_n), .arb(bac_if_i), .want_bus(want_bus),
    .cyc_go(cyc_go), .cyc_addr(cyc_addr), .cyc_wdata(cyc_wdata), .cyc_write(cyc_write),
    .owner(owner), .requesting());
  bac_properties bac_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .br(bac_if_i.br),
    .bg(bac_if_i.bg), .grant_acknowledge(bac_if_i.grant_acknowledge), .dev_addr_oe(bac_if_i.dev_addr_oe),
    .dev_as(bac_if_i.dev_as), .dev_ds(bac_if_i.dev_ds), .dev_data_oe(bac_if_i.dev_data_oe),
    .ext_as(bac_if_i.ext_as), .ext_ds(bac_if_i.ext_ds));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // A hung handshake must still reach the verdict
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic do_reset(input logic s);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask : do_reset

  task automatic set_shen(input logic [1:0] v);
    @(posedge sys_clk);
    shen_wr <= 1'b1;
    shen_wdata <= v;
    @(posedge sys_clk);
    shen_wr <= 1'b0;
    @(negedge sys_clk);
    chk("show enable", {22'h0, v}, {22'h0, show_cycle_enable});
  endtask : set_shen

  // Request is held until taken, then the bus is sampled mid-cycle
  task automatic dev_cycle(input logic [23:0] a, input logic w, input bac_size_t sz,
                           input logic [15:0] d, input logic in, input logic last);
    int n;
    @(posedge sys_clk);
    int_addr <= a;
    int_write <= w;
    int_size <= sz;
    int_wdata <= d;
    int_is_internal <= in;
    int_last <= last;
    int_req <= 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (int_ready !== 1'b1 && n < 60);
    @(posedge sys_clk);
    int_req <= 1'b0;
    repeat (2) @(negedge sys_clk);
    seen_as = bac_if_i.as;
    seen_ds = bac_if_i.ds;
    seen_data = bac_if_i.data;
    seen_addr = bac_if_i.addr;
    seen_size = bac_if_i.dev_size;
    n = 0;
    while (int_done !== 1'b1 && n < 8) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cycle done", 24'h1, {23'h0, int_done});
  endtask : dev_cycle

  task automatic hold_bus(input logic v);
    int n;
    @(posedge sys_clk);
    want_bus <= v;
    n = 0;
    while (owner !== v && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (4) @(negedge sys_clk);
    chk("owner", {23'h0, v}, {23'h0, owner});
    chk("device address drive", {23'h0, !v}, {23'h0, bac_if_i.dev_addr_oe});
  endtask : hold_bus

  initial begin
    {rst_n, strap, halt_in, dbl_fault, shen_wr, int_req, want_bus, cyc_go} = 8'h0;
    {int_write, int_is_internal, int_last, cyc_write, shen_wdata} = 6'h0;
    {int_addr, cyc_addr, int_wdata, cyc_wdata} = '0;
    int_size = BAC_SZ_WORD;
    int_rdata = 16'h5aa5;
    {fails, checks_done, cycles} = '0;
    do_reset(1'b0);
    chk("show enable at reset", 24'h0, {22'h0, show_cycle_enable});
    dev_cycle(24'h000102, 1'b0, BAC_SZ_WORD, 16'h1234, 1'b1, 1'b1);
    chk("address strobe, show off", 24'h0, {23'h0, seen_as});
    chk("strobe, show off", 24'h0, {23'h0, seen_ds});
    chk("data, show off", 24'hffff, {8'h0, seen_data});
    chk("address, show off", 24'h000102, seen_addr);
    for (k = 1; k < 3; k++) begin
      set_shen(k[1:0]);
      dev_cycle(24'h000200, 1'b1, BAC_SZ_WORD, 16'hbeef, 1'b1, 1'b1);
      chk("address strobe, show", 24'h0, {23'h0, seen_as});
      chk("data strobe, show", 24'h1, {23'h0, seen_ds});
      chk("data, show", 24'hbeef, {8'h0, seen_data});
    end
    for (k = 0; k < 2; k++) begin
      dev_cycle({23'h000102, k[0]}, 1'b1, BAC_SZ_BYTE, 16'h00c3, 1'b1, 1'b1);
      chk("size, show", {22'h0, BAC_SZ_BYTE}, {22'h0, seen_size});
      chk("byte lanes, show", k[0] ? 24'h005ac3 : 24'h00c3a5,
          {8'h0, seen_data});
    end
    dev_cycle(24'h010001, 1'b1, BAC_SZ_BYTE, 16'h003c, 1'b0, 1'b1);
    chk("byte lanes, external", 24'h3c3c, {8'h0, seen_data});
    dev_cycle(24'h010010, 1'b1, BAC_SZ_WORD, 16'h1111, 1'b0, 1'b0);
    @(posedge sys_clk);
    want_bus <= 1'b1;
    repeat (8) @(negedge sys_clk);
    chk("grant inside operand", 24'h0, {23'h0, bac_if_i.bg});
    dev_cycle(24'h010012, 1'b1, BAC_SZ_WORD, 16'h2222, 1'b0, 1'b1);
    hold_bus(1'b1);
    chk("device sees ack", 24'h1, {23'h0, ext_owned});
    dev_cycle(24'h000300, 1'b0, BAC_SZ_WORD, 16'h0, 1'b1, 1'b1);
    @(posedge sys_clk);
    cyc_addr <= 24'h0a0b0c;
    cyc_wdata <= 16'h9c6e;
    cyc_write <= 1'b1;
    cyc_go <= 1'b1;
    @(posedge sys_clk);
    cyc_go <= 1'b0;
    k = 0;
    while (bac_if_i.ext_as !== 1'b1 && k < 10) begin
      @(negedge sys_clk);
      k++;
    end
    chk("outside master strobe", 24'h1, {23'h0, bac_if_i.as});
    chk("outside master address", 24'h0a0b0c, bac_if_i.addr);
    chk("outside master data", 24'h9c6e, {8'h0, bac_if_i.data});
    set_shen(2'h3);
    @(posedge sys_clk);
    int_req <= 1'b1;
    k = 0;
    repeat (6) begin
      @(negedge sys_clk);
      if (int_ready !== 1'b0) begin
        k++;
      end
    end
    chk("internal taken under stall", 24'h0, k[23:0]);
    hold_bus(1'b0);
    dev_cycle(24'h000300, 1'b0, BAC_SZ_WORD, 16'h0, 1'b1, 1'b1);
    set_shen(2'h0);
    @(posedge sys_clk);
    want_bus <= 1'b1;
    @(posedge sys_clk);
    want_bus <= 1'b0;
    repeat (12) @(negedge sys_clk);
    chk("grant after withdrawal", 24'h0, {23'h0, bac_if_i.bg});
    dev_cycle(24'h010020, 1'b0, BAC_SZ_WORD, 16'h0, 1'b0, 1'b1);
    // Nobody drives the data lines on this read, so the pull-up level comes back
    chk("outside read data", 24'hffff, {8'h0, ext_rdata});
    @(posedge sys_clk);
    halt_in <= 1'b1;
    dbl_fault <= 1'b1;
    hold_bus(1'b1);
    hold_bus(1'b0);
    chk("address restored", 24'h010020, bac_if_i.addr);
    @(posedge sys_clk);
    halt_in <= 1'b0;
    dbl_fault <= 1'b0;
    do_reset(1'b1);
    chk("chip select mode", 24'h1, {23'h0, cs_mode});
    @(posedge sys_clk);
    want_bus <= 1'b1;
    repeat (12) @(negedge sys_clk);
    chk("grant with strap high", 24'h0, {23'h0, bac_if_i.bg});
    do_reset(1'b0);
    hold_bus(1'b1);
    hold_bus(1'b0);
    final_report();
  end
endmodule : bus_arbitration_show_cycles_tb
